// ### core/gst_pkg.sv
// Constants, types and register map of the gated sweep trigger control
package gst_pkg;

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  localparam int          CLK_NS     = 25;
  localparam int          TICK_NS    = 125;
  localparam int          TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  TICK_LAST  = 3'(TICK_CYC - 1);
  localparam longint      GATE_MIN_NS = 125;
  localparam longint      GATE_MAX_NS = 64'd100_000_000_000;
  localparam logic [29:0] CNT_MIN    = 30'((GATE_MIN_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [29:0] CNT_MAX    = 30'(GATE_MAX_NS / TICK_NS);
  localparam int          CNT_W      = 30;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GDELAY = 8'h04;
  localparam logic [7:0] ADDR_GLEN   = 8'h08;
  localparam logic [7:0] ADDR_TDELAY = 8'h0c;
  localparam logic [7:0] ADDR_TV     = 8'h10;
  localparam logic [7:0] ADDR_LINE   = 8'h14;
  localparam logic [7:0] ADDR_STAT   = 8'h18;

  // ----------------------------------------
  // Encodings and field layouts
  // ----------------------------------------
  typedef enum logic [1:0] {GSRC_EXT = 2'h0, GSRC_IFP = 2'h1, GSRC_RFP = 2'h2, GSRC_BAD = 2'h3} gst_gsrc_t;
  typedef enum logic [2:0] {TSRC_FREE = 3'h0, TSRC_EXT = 3'h1, TSRC_IFP = 3'h2,
                            TSRC_RFP = 3'h3, TSRC_TV = 3'h4} gst_tsrc_t;
  typedef enum logic [1:0] {FSEL_ALL = 2'h0, FSEL_ODD = 2'h1, FSEL_EVEN = 2'h2, FSEL_LINE = 2'h3} gst_fsel_t;

  // Bit 0 upward: gate_en, edge_mode, pol_neg, gsrc[4:3], tsrc[7:5], dcomp
  typedef struct packed {
    logic      dcomp;
    gst_tsrc_t tsrc;
    gst_gsrc_t gsrc;
    logic      pol_neg;
    logic      edge_mode;
    logic      gate_en;
  } gst_ctrl_t;
  localparam int CTRL_W = 9;

  // Bit 0 upward: on, fsel[2:1], video_pos, lines525, ccvs_ext
  typedef struct packed {
    logic      ccvs_ext;
    logic      lines525;
    logic      video_pos;
    gst_fsel_t fsel;
    logic      on;
  } gst_tv_t;
  localparam int TV_W = 6;

  localparam gst_ctrl_t CTRL_RST = '{dcomp: 1'b0, tsrc: TSRC_FREE, gsrc: GSRC_EXT,
                                     pol_neg: 1'b0, edge_mode: 1'b0, gate_en: 1'b0};
  localparam gst_tv_t   TV_RST   = '{ccvs_ext: 1'b0, lines525: 1'b0, video_pos: 1'b0,
                                     fsel: FSEL_ALL, on: 1'b0};

  localparam int         LINE_W       = 10;
  localparam logic [9:0] LINE_DEF     = 10'd17;
  localparam logic [9:0] LINE_MAX_625 = 10'd625;
  localparam logic [9:0] LINE_MAX_525 = 10'd525;
  localparam logic [9:0] LINE_MIN     = 10'd1;

  // ----------------------------------------
  // Synchronised pin indices
  // ----------------------------------------
  localparam int PIN_EXT  = 0;
  localparam int PIN_IFP  = 1;
  localparam int PIN_RFP  = 2;
  localparam int PIN_VODD = 3;
  localparam int PIN_VEVN = 4;
  localparam int PIN_HS   = 5;
  localparam int PIN_N    = 6;

  // Status bit positions
  localparam int STAT_SWEEP = 0;
  localparam int STAT_GATE  = 1;
  localparam int STAT_TPEND = 2;

endpackage : gst_pkg

// ### core/gst_top.sv
// Gated sweep and trigger control with APB register access
// Behaviour
// - Level mode: pause on low, resume after delay
// - Edge mode: rise, delay, sweep gate length
// - Gate delay programmable 125 ns to 100 s
// - Gate length programmable 125 ns to 100 s
// - Level mode ignores gate length writes
// - One polarity serves gate and trigger
// - Gate delay write also sets trigger delay when trigger source is external or IF detector
// - Gate active indication while gating enabled
// - Wideband detector selectable for gate, trigger
// - Wideband trigger fires on detector threshold
// - TV trigger selectable only at zero span
// - TV trigger off selects free run
// - All-fields mode fires on every odd and every even frame sync
// - Odd-only or even-only frame sync trigger
// - Line trigger clamped to system maximum
// - TV trigger on sets line 17
// - Video sense selectable, negative default
// - Line system 625 or 525, default 625
// - Composite video internal or external source
// - Delay compensation enable, default off
// - Gating forces detector source when needed; done on control writes only, TV writes still select TV or free run
//
// Our own choices: register access over APB and the placing of the registers.
module gst_top
  import gst_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Asynchronous gate, detector and sync inputs
  input  wire logic        EXTERNAL_CONTROL_LINE,
  input  wire logic        IF_DETECTOR,
  input  wire logic        FIRST_IF_WIDEBAND_DETECTOR,
  input  wire logic        FRAME_SYNC_ODD,
  input  wire logic        FRAME_SYNC_EVEN,
  input  wire logic        LINE_SYNC,
  // Span state from sweep logic
  input  wire logic        ZERO_SPAN,
  // Sweep control
  output logic             SWEEP_ENABLE,
  output logic             SWEEP_TRIGGER,
  output logic             FREE_RUN,
  output logic             GATE_ACTIVE_LABEL,
  // Sync separator and compensation control
  output logic             VIDEO_SENSE_POS,
  output logic             COMPOSITE_VIDEO_EXT,
  output logic             DELAY_COMP_EN
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [CNT_W-1:0] clamp_cnt(input logic [31:0] v, input logic [CNT_W-1:0] lo);
    if (v < 32'(lo))
      return lo;
    else if (v > 32'(CNT_MAX))
      return CNT_MAX;
    else
      return v[CNT_W-1:0];
  endfunction : clamp_cnt

  function automatic logic [LINE_W-1:0] clamp_line(input logic [31:0] v, input logic sys525);
    logic [LINE_W-1:0] mx;
    mx = sys525 ? LINE_MAX_525 : LINE_MAX_625;
    if (v < 32'(LINE_MIN))
      return LINE_MIN;
    else if (v > 32'(mx))
      return mx;
    else
      return v[LINE_W-1:0];
  endfunction : clamp_line

  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hits

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_m_q;
  logic [PIN_N-1:0] pin_s_q;
  logic [PIN_N-1:0] pin_p_q;

  assign pin_raw = {LINE_SYNC, FRAME_SYNC_EVEN, FRAME_SYNC_ODD,
                    FIRST_IF_WIDEBAND_DETECTOR, IF_DETECTOR, EXTERNAL_CONTROL_LINE};

  for (genvar i = 0; i < PIN_N; i++)
  begin : g_sync
    always_ff @(posedge CORE_CLK)
    begin
      pin_m_q[i] <= RST ? 1'b0 : pin_raw[i];
      pin_s_q[i] <= RST ? 1'b0 : pin_m_q[i];
      pin_p_q[i] <= RST ? 1'b0 : pin_s_q[i];
    end
  end

  wire logic [PIN_N-1:0] pin_rise = pin_s_q & ~pin_p_q;

  // ----------------------------------------
  // 125 ns tick
  // ----------------------------------------
  logic [2:0] div_q;
  wire  logic tick = (div_q == TICK_LAST);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || tick)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  gst_ctrl_t         ctrl_q, ctrl_d;
  gst_tv_t           tv_q, tv_d;
  logic [CNT_W-1:0]  gdly_q, gdly_d;
  logic [CNT_W-1:0]  glen_q, glen_d;
  logic [CNT_W-1:0]  tdly_q, tdly_d;
  logic [LINE_W-1:0] line_q, line_d;

  wire logic access   = PSEL & PENABLE;
  wire logic wr       = access & PWRITE;
  wire logic mapped   = hits(PADDR, ADDR_CTRL) | hits(PADDR, ADDR_GDELAY) | hits(PADDR, ADDR_GLEN) |
                        hits(PADDR, ADDR_TDELAY) | hits(PADDR, ADDR_TV) | hits(PADDR, ADDR_LINE) |
                        hits(PADDR, ADDR_STAT);
  wire logic wr_ctrl  = wr & hits(PADDR, ADDR_CTRL);
  wire logic wr_gdly  = wr & hits(PADDR, ADDR_GDELAY);
  wire logic wr_glen  = wr & hits(PADDR, ADDR_GLEN);
  wire logic wr_tdly  = wr & hits(PADDR, ADDR_TDELAY);
  wire logic wr_tv    = wr & hits(PADDR, ADDR_TV);
  wire logic wr_line  = wr & hits(PADDR, ADDR_LINE);

  wire gst_ctrl_t w_ctrl = gst_ctrl_t'(PWDATA[CTRL_W-1:0]);
  wire gst_tv_t   w_tv   = gst_tv_t'(PWDATA[TV_W-1:0]);
  wire logic shared_in   = (ctrl_q.tsrc == TSRC_EXT) || (ctrl_q.tsrc == TSRC_IFP);
  wire logic tsrc_ok     = (w_ctrl.tsrc <= TSRC_TV) && ((w_ctrl.tsrc != TSRC_TV) || ZERO_SPAN);
  wire logic tsrc_det    = (w_ctrl.tsrc == TSRC_EXT) || (w_ctrl.tsrc == TSRC_IFP) || (w_ctrl.tsrc == TSRC_RFP);
  wire logic tv_on_ok    = w_tv.on & (tv_q.on | ZERO_SPAN);

  always_comb
  begin
    ctrl_d = ctrl_q;
    tv_d   = tv_q;
    gdly_d = gdly_q;
    glen_d = glen_q;
    tdly_d = tdly_q;
    line_d = line_q;
    if (wr_ctrl)
    begin
      ctrl_d.gate_en   = w_ctrl.gate_en;
      ctrl_d.edge_mode = w_ctrl.edge_mode;
      ctrl_d.pol_neg   = w_ctrl.pol_neg;
      ctrl_d.dcomp     = w_ctrl.dcomp;
      if (w_ctrl.gsrc != GSRC_BAD)
        ctrl_d.gsrc = w_ctrl.gsrc;
      if (tsrc_ok)
        ctrl_d.tsrc = w_ctrl.tsrc;
      if (w_ctrl.gate_en && !(tsrc_ok ? tsrc_det :
          (ctrl_q.tsrc == TSRC_EXT || ctrl_q.tsrc == TSRC_IFP || ctrl_q.tsrc == TSRC_RFP)))
        ctrl_d.tsrc = TSRC_IFP;
    end
    if (wr_gdly)
    begin
      gdly_d = clamp_cnt(PWDATA, CNT_MIN);
      if (shared_in)
        tdly_d = clamp_cnt(PWDATA, CNT_MIN);
    end
    if (wr_glen && ctrl_q.edge_mode)
      glen_d = clamp_cnt(PWDATA, CNT_MIN);
    if (wr_tdly)
      tdly_d = clamp_cnt(PWDATA, '0);
    if (wr_tv)
    begin
      tv_d.fsel      = w_tv.fsel;
      tv_d.video_pos = w_tv.video_pos;
      tv_d.lines525  = w_tv.lines525;
      tv_d.ccvs_ext  = w_tv.ccvs_ext;
      tv_d.on        = tv_on_ok;
      line_d         = clamp_line(32'(line_q), w_tv.lines525);
      if (tv_on_ok && !tv_q.on)
      begin
        line_d      = LINE_DEF;
        ctrl_d.tsrc = TSRC_TV;
      end
      if (!tv_on_ok && tv_q.on)
        ctrl_d.tsrc = TSRC_FREE;
    end
    if (wr_line)
      line_d = clamp_line(PWDATA, tv_q.lines525);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ctrl_q <= CTRL_RST;
      tv_q   <= TV_RST;
      gdly_q <= CNT_MIN;
      glen_q <= CNT_MIN;
      tdly_q <= '0;
      line_q <= LINE_DEF;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      tv_q   <= tv_d;
      gdly_q <= gdly_d;
      glen_q <= glen_d;
      tdly_q <= tdly_d;
      line_q <= line_d;
    end
  end

  // ----------------------------------------
  // Gate sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {G_WAIT, G_DELAY, G_OPEN} gst_gate_st_t;
  gst_gate_st_t     gst_q, gst_d;
  logic [CNT_W-1:0] gcnt_q, gcnt_d;
  logic             glvl_q;

  wire logic gate_raw = (ctrl_q.gsrc == GSRC_RFP) ? pin_s_q[PIN_RFP] :
                        (ctrl_q.gsrc == GSRC_IFP) ? pin_s_q[PIN_IFP] : pin_s_q[PIN_EXT];
  wire logic glvl     = gate_raw ^ ctrl_q.pol_neg;
  wire logic grise    = glvl & ~glvl_q;
  wire logic gcnt_end = tick && (gcnt_q <= 30'd1);

  always_comb
  begin
    gst_d  = gst_q;
    gcnt_d = gcnt_q;
    unique case (gst_q)
      G_WAIT:
        if (grise)
        begin
          gst_d  = G_DELAY;
          gcnt_d = gdly_q;
        end
      G_DELAY:
        if (!ctrl_q.edge_mode && !glvl)
          gst_d = G_WAIT;
        else if (gcnt_end)
        begin
          gst_d  = G_OPEN;
          gcnt_d = glen_q;
        end
        else if (tick)
          gcnt_d = gcnt_q - 30'd1;
      G_OPEN:
        if (!ctrl_q.edge_mode)
        begin
          if (!glvl)
            gst_d = G_WAIT;
        end
        else if (gcnt_end)
          gst_d = G_WAIT;
        else if (tick)
          gcnt_d = gcnt_q - 30'd1;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || !ctrl_q.gate_en)
    begin
      gst_q  <= G_WAIT;
      gcnt_q <= '0;
      glvl_q <= RST | ctrl_q.edge_mode;
    end
    else
    begin
      gst_q  <= gst_d;
      gcnt_q <= gcnt_d;
      glvl_q <= glvl;
    end
  end

  // ----------------------------------------
  // TV sync events
  // ----------------------------------------
  logic [LINE_W-1:0] lcnt_q;
  wire  logic        vs_any = pin_rise[PIN_VODD] | pin_rise[PIN_VEVN];
  wire  logic [LINE_W-1:0] lcnt_nx = lcnt_q + 10'd1;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || vs_any)
      lcnt_q <= '0;
    else if (pin_rise[PIN_HS] && lcnt_q != '1)
      lcnt_q <= lcnt_nx;
  end

  logic tv_ev;
  always_comb
  begin
    unique case (tv_q.fsel)
      FSEL_ALL:  tv_ev = vs_any;
      FSEL_ODD:  tv_ev = pin_rise[PIN_VODD];
      FSEL_EVEN: tv_ev = pin_rise[PIN_VEVN];
      FSEL_LINE: tv_ev = pin_rise[PIN_HS] && (lcnt_nx == line_q);
    endcase
  end

  // ----------------------------------------
  // Trigger path
  // ----------------------------------------
  logic             tlvl_q;
  logic             tpend_q;
  logic [CNT_W-1:0] tcnt_q;
  logic             trig_q;

  wire logic trig_raw = (ctrl_q.tsrc == TSRC_RFP) ? pin_s_q[PIN_RFP] :
                        (ctrl_q.tsrc == TSRC_IFP) ? pin_s_q[PIN_IFP] : pin_s_q[PIN_EXT];
  wire logic tlvl     = trig_raw ^ ctrl_q.pol_neg;
  wire logic det_src  = (ctrl_q.tsrc == TSRC_EXT) || (ctrl_q.tsrc == TSRC_IFP) || (ctrl_q.tsrc == TSRC_RFP);
  wire logic tev      = det_src ? (tlvl & ~tlvl_q) :
                        ((ctrl_q.tsrc == TSRC_TV) && tv_q.on && tv_ev);
  wire logic tstart   = tev && !tpend_q;
  wire logic tfire    = (tstart && tdly_q == '0) || (tpend_q && tick && tcnt_q <= 30'd1);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      tlvl_q  <= 1'b1;
      tpend_q <= 1'b0;
      tcnt_q  <= '0;
      trig_q  <= 1'b0;
    end
    else
    begin
      tlvl_q <= tlvl;
      trig_q <= tfire;
      if (tstart && tdly_q != '0)
      begin
        tpend_q <= 1'b1;
        tcnt_q  <= tdly_q;
      end
      else if (tfire)
        tpend_q <= 1'b0;
      else if (tpend_q && tick)
        tcnt_q <= tcnt_q - 30'd1;
    end
  end

  // ----------------------------------------
  // Outputs and read data
  // ----------------------------------------
  logic [31:0] rdata;
  always_comb
  begin
    unique case (1'b1)
      hits(PADDR, ADDR_CTRL):   rdata = 32'(ctrl_q);
      hits(PADDR, ADDR_GDELAY): rdata = 32'(gdly_q);
      hits(PADDR, ADDR_GLEN):   rdata = 32'(glen_q);
      hits(PADDR, ADDR_TDELAY): rdata = 32'(tdly_q);
      hits(PADDR, ADDR_TV):     rdata = 32'(tv_q);
      hits(PADDR, ADDR_LINE):   rdata = 32'(line_q);
      hits(PADDR, ADDR_STAT):   rdata = 32'({tpend_q, ctrl_q.gate_en, SWEEP_ENABLE});
      default:                  rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      PRDATA            <= 32'h0;
      SWEEP_ENABLE      <= 1'b1;
      GATE_ACTIVE_LABEL <= 1'b0;
    end
    else
    begin
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rdata;
      SWEEP_ENABLE      <= !ctrl_q.gate_en || (gst_q == G_OPEN);
      GATE_ACTIVE_LABEL <= ctrl_q.gate_en;
    end
  end

  assign PREADY              = 1'b1;
  assign PSLVERR             = access & ~mapped;
  assign SWEEP_TRIGGER       = trig_q;
  assign FREE_RUN            = (ctrl_q.tsrc == TSRC_FREE);
  assign VIDEO_SENSE_POS     = tv_q.video_pos;
  assign COMPOSITE_VIDEO_EXT = tv_q.ccvs_ext;
  assign DELAY_COMP_EN       = ctrl_q.dcomp;

endmodule : gst_top

// ### tb/gst_top_chk.sv
// Port checker for the gated sweep trigger control
module gst_top_chk
  import gst_pkg::*;
(
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // Gate line and span
  input wire logic        EXTERNAL_CONTROL_LINE,
  input wire logic        ZERO_SPAN,
  // Outputs
  input wire logic        SWEEP_ENABLE,
  input wire logic        FREE_RUN,
  input wire logic        GATE_ACTIVE_LABEL,
  input wire logic        VIDEO_SENSE_POS,
  input wire logic        COMPOSITE_VIDEO_EXT,
  input wire logic        DELAY_COMP_EN
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Shadow of the settings
  // ----------------------------------------
  logic        gate_q;
  logic        edge_q;
  logic        pol_q;
  logic        tv_on_q;
  logic        se_q;
  logic [1:0]  gsrc_q;
  logic [29:0] glen_q;
  logic [31:0] run_q;
  wire         acc      = PSEL && PENABLE && PWRITE;
  wire         wr_ctrl  = acc && PADDR == ADDR_CTRL;
  wire         wr_tv    = acc && PADDR == ADDR_TV;
  wire         wr_glen  = acc && PADDR == ADDR_GLEN;
  wire         lvl_cfg  = gate_q && !edge_q && !pol_q && gsrc_q == GSRC_EXT;
  wire         edge_cfg = gate_q && edge_q && !pol_q && gsrc_q == GSRC_EXT;
  wire  [31:0] len_lo   = 32'(TICK_CYC * (glen_q - 30'd1));
  wire  [31:0] len_hi   = 32'(TICK_CYC * glen_q + 1);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      gate_q  <= 1'b0;
      edge_q  <= 1'b0;
      pol_q   <= 1'b0;
      tv_on_q <= 1'b0;
      se_q    <= 1'b1;
      gsrc_q  <= 2'h0;
      glen_q  <= 30'h1;
      run_q   <= 32'h0;
    end
    else
    begin
      se_q <= SWEEP_ENABLE;
      if (wr_ctrl)
      begin
        gate_q <= PWDATA[0];
        edge_q <= PWDATA[1];
        pol_q  <= PWDATA[2];
        if (PWDATA[4:3] != 2'h3) gsrc_q <= PWDATA[4:3];
      end
      if (wr_glen && edge_q) glen_q <= (PWDATA[29:0] == 30'h0) ? 30'h1 : PWDATA[29:0];
      if (wr_tv) tv_on_q <= PWDATA[0] && (tv_on_q || ZERO_SPAN);
      if (!edge_cfg || !SWEEP_ENABLE) run_q <= 32'h0;
      else if (run_q != 32'h0 || !se_q) run_q <= run_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_ctrl_wr;
    wr_ctrl;
  endsequence
  sequence s_tv_wr;
    wr_tv && (!PWDATA[0] || ZERO_SPAN || tv_on_q);
  endsequence
  sequence s_gate_low;
    (lvl_cfg && !EXTERNAL_CONTROL_LINE) [*6];
  endsequence

  property p_gate_label;
    s_ctrl_wr ##0 PWDATA[0] |-> ##[1:2] GATE_ACTIVE_LABEL;
  endproperty
  property p_dcomp;
    s_ctrl_wr |=> DELAY_COMP_EN == $past(PWDATA[8]);
  endproperty
  property p_vsense;
    s_tv_wr |=> VIDEO_SENSE_POS == $past(PWDATA[3]);
  endproperty
  property p_ccvs;
    s_tv_wr |=> COMPOSITE_VIDEO_EXT == $past(PWDATA[5]);
  endproperty
  property p_force_if;
    s_ctrl_wr ##0 (PWDATA[0] && PWDATA[7:5] == 3'h0) |=> !FREE_RUN;
  endproperty
  property p_tv_off;
    wr_tv && tv_on_q && !PWDATA[0] |=> FREE_RUN;
  endproperty
  property p_tv_refused;
    s_ctrl_wr ##0 (PWDATA[7:5] == 3'h4 && !PWDATA[0] && !ZERO_SPAN && FREE_RUN) |=> FREE_RUN;
  endproperty
  property p_level_pause;
    s_gate_low |-> !SWEEP_ENABLE;
  endproperty
  property p_level_resume;
    lvl_cfg && $rose(SWEEP_ENABLE) |-> $past(EXTERNAL_CONTROL_LINE, 4);
  endproperty
  property p_edge_len;
    edge_cfg && $fell(SWEEP_ENABLE) && run_q != 32'h0 |-> run_q >= len_lo && run_q <= len_hi;
  endproperty

  a_gate_label: assert property (p_gate_label) else $error("gate label not raised");
  a_dcomp: assert property (p_dcomp) else $error("delay compensation not as written");
  a_vsense: assert property (p_vsense) else $error("video sense not as written");
  a_ccvs: assert property (p_ccvs) else $error("video source not as written");
  a_force_if: assert property (p_force_if) else $error("gating left free run");
  a_tv_off: assert property (p_tv_off) else $error("tv off did not select free run");
  a_tv_refused: assert property (p_tv_refused) else $error("tv source taken outside zero span");
  a_level_pause: assert property (p_level_pause) else $error("sweep runs with gate low");
  a_level_resume: assert property (p_level_resume) else $error("sweep resumed too early");
  a_edge_len: assert property (p_edge_len) else $error("edge window length wrong");
endmodule : gst_top_chk

bind gst_top gst_top_chk gst_top_chk_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .EXTERNAL_CONTROL_LINE(EXTERNAL_CONTROL_LINE),
  .ZERO_SPAN(ZERO_SPAN), .SWEEP_ENABLE(SWEEP_ENABLE), .FREE_RUN(FREE_RUN),
  .GATE_ACTIVE_LABEL(GATE_ACTIVE_LABEL), .VIDEO_SENSE_POS(VIDEO_SENSE_POS),
  .COMPOSITE_VIDEO_EXT(COMPOSITE_VIDEO_EXT), .DELAY_COMP_EN(DELAY_COMP_EN)
);

// ### tb/gst_src_model.sv
// Model of the gate, detector and sync separator sources
module gst_src_model
  import gst_pkg::*;
(
  // Clock
  input wire logic         clk,
  // Source levels
  output logic [PIN_N-1:0] sync_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial sync_o = '0;

  // Change one line after an edge, then hold it
  task automatic drive(input int i, input logic v, input int n);
    @(posedge clk);
    sync_o[i] <= v;
    repeat (n) @(posedge clk);
  endtask : drive
endmodule : gst_src_model

// ### tb/tb.sv
// Self-checking testbench of the gated sweep trigger control
module tb
  import gst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e; logic [3:0] p;} gst_row_t;
  logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, ZERO_SPAN, PREADY, PSLVERR, e;
  logic SWEEP_ENABLE, SWEEP_TRIGGER, FREE_RUN, GATE_ACTIVE_LABEL, VIDEO_SENSE_POS, COMPOSITE_VIDEO_EXT, DELAY_COMP_EN;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [PIN_N-1:0] pins;
  int n_fail, n_compared, t, c, f, k;
  gst_row_t rows [35] = '{
    '{0,ADDR_CTRL,0,0,0,1}, '{0,ADDR_GDELAY,0,1,0,1}, '{0,ADDR_GLEN,0,1,0,1}, '{0,ADDR_TDELAY,0,0,0,1},
    '{0,ADDR_TV,0,0,0,1}, '{0,ADDR_LINE,0,17,0,1}, '{0,8'h1c,0,0,1,1}, '{1,8'h1c,'hff,0,1,1},
    '{1,ADDR_GDELAY,0,0,0,1}, '{0,ADDR_GDELAY,0,1,0,1}, '{1,ADDR_GDELAY,'h3fffffff,0,0,1},
    '{0,ADDR_GDELAY,0,'h2faf0800,0,1}, '{1,ADDR_GLEN,7,0,0,1}, '{0,ADDR_GLEN,0,1,0,1},
    '{1,ADDR_LINE,700,0,0,1}, '{0,ADDR_LINE,0,625,0,1}, '{1,ADDR_LINE,0,0,0,1}, '{0,ADDR_LINE,0,1,0,1},
    '{1,ADDR_LINE,600,0,0,1}, '{1,ADDR_TV,1,0,0,1}, '{0,ADDR_TV,0,0,0,1}, '{1,ADDR_TV,'h10,0,0,1},
    '{0,ADDR_LINE,0,525,0,1}, '{1,ADDR_TV,'h28,0,0,'hd}, '{1,ADDR_CTRL,'h80,0,0,'hd}, '{0,ADDR_CTRL,0,0,0,'hd},
    '{1,ADDR_CTRL,'h120,0,0,'he}, '{1,ADDR_GDELAY,3,0,0,'he}, '{0,ADDR_TDELAY,0,3,0,'he},
    '{1,ADDR_CTRL,'h70,0,0,'hc}, '{0,ADDR_CTRL,0,'h70,0,'hc}, '{1,ADDR_CTRL,1,0,0,'hc},
    '{0,ADDR_CTRL,0,'h41,0,'hc}, '{1,ADDR_CTRL,0,0,0,'hd}, '{1,ADDR_TV,0,0,0,1}};

  gst_top gst_top_i (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXTERNAL_CONTROL_LINE(pins[PIN_EXT]), .IF_DETECTOR(pins[PIN_IFP]), .FIRST_IF_WIDEBAND_DETECTOR(pins[PIN_RFP]),
    .FRAME_SYNC_ODD(pins[PIN_VODD]), .FRAME_SYNC_EVEN(pins[PIN_VEVN]), .LINE_SYNC(pins[PIN_HS]),
    .ZERO_SPAN(ZERO_SPAN), .SWEEP_ENABLE(SWEEP_ENABLE), .SWEEP_TRIGGER(SWEEP_TRIGGER), .FREE_RUN(FREE_RUN),
    .GATE_ACTIVE_LABEL(GATE_ACTIVE_LABEL), .VIDEO_SENSE_POS(VIDEO_SENSE_POS),
    .COMPOSITE_VIDEO_EXT(COMPOSITE_VIDEO_EXT), .DELAY_COMP_EN(DELAY_COMP_EN));
  gst_src_model gst_src_model_i (.clk(CORE_CLK), .sync_o(pins));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  // Change a source line and count trigger pulses meanwhile
  task automatic act(input int i, input logic v, input int n, output int cnt);
    cnt = 0;
    fork
      gst_src_model_i.drive(i, v, 2);
      repeat (n)
      begin
        @(posedge CORE_CLK);
        if (SWEEP_TRIGGER === 1'b1) cnt++;
      end
    join
  endtask : act

  task automatic wait_se(input logic v, output int n);
    n = 0;
    while (SWEEP_ENABLE !== v)
    begin
      @(posedge CORE_CLK);
      n++;
      if (n > 200)
      begin
        n_fail++;
        print_verdict();
      end
    end
  endtask : wait_se

  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial
  begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {RST, PSEL, PENABLE, PWRITE, ZERO_SPAN, PADDR, PWDATA} = {1'b1, 44'h0};
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    chk("reset_outs", 32'he0, {24'h0, PREADY, SWEEP_ENABLE, FREE_RUN, GATE_ACTIVE_LABEL, VIDEO_SENSE_POS,
        COMPOSITE_VIDEO_EXT, DELAY_COMP_EN, SWEEP_TRIGGER});
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      @(posedge CORE_CLK);
      chk("pslverr", rows[i].e, e);
      if (!rows[i].w) chk("prdata", rows[i].r, r);
      chk("pins", rows[i].p, {VIDEO_SENSE_POS, COMPOSITE_VIDEO_EXT, DELAY_COMP_EN, FREE_RUN});
    end
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_GDELAY, 32'h2);
    repeat (10) @(posedge CORE_CLK);
    chk("level_pause", 32'h1, {SWEEP_ENABLE, GATE_ACTIVE_LABEL});
    apb(1'b0, ADDR_STAT, 32'h0, r, e);
    chk("status", 32'h2, r);
    gst_src_model_i.drive(PIN_EXT, 1'b1, 0);
    wait_se(1'b1, t);
    chk("level_delay", 1, t >= TICK_CYC + 2 && t <= TICK_CYC * 2 + 6);
    gst_src_model_i.drive(PIN_EXT, 1'b0, 0);
    wait_se(1'b0, t);
    chk("level_stop", 1, t <= 6);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_GLEN, 32'h3);
    wr(ADDR_GDELAY, 32'h1);
    gst_src_model_i.drive(PIN_EXT, 1'b1, 3);
    gst_src_model_i.drive(PIN_EXT, 1'b0, 0);
    wait_se(1'b1, t);
    wait_se(1'b0, t);
    chk("edge_len", 1, t >= TICK_CYC * 2 && t <= TICK_CYC * 3 + 1);
    repeat (15) @(posedge CORE_CLK);
    chk("edge_closed", 0, SWEEP_ENABLE);
    wr(ADDR_CTRL, 32'h0);
    gst_src_model_i.drive(PIN_EXT, 1'b1, 4);
    wr(ADDR_CTRL, 32'h24);
    wr(ADDR_TDELAY, 32'h0);
    act(PIN_EXT, 1'b0, 12, c);
    chk("neg_trig", 1, c);
    act(PIN_EXT, 1'b1, 12, c);
    chk("pos_quiet", 0, c);
    wr(ADDR_CTRL, 32'h60);
    act(PIN_RFP, 1'b1, 12, c);
    chk("wideband_trig", 1, c);
    act(PIN_RFP, 1'b0, 6, c);
    ZERO_SPAN <= 1'b1;
    wr(ADDR_LINE, 32'h5);
    wr(ADDR_TV, 32'h1);
    apb(1'b0, ADDR_LINE, 32'h0, r, e);
    chk("tv_line", 17, r);
    chk("tv_source", 0, FREE_RUN);
    for (f = 0; f < 3; f++)
    begin
      wr(ADDR_TV, 32'(1 + 2 * f));
      act(PIN_VODD, 1'b1, 10, c);
      chk("odd_field", f != 2, c);
      act(PIN_VODD, 1'b0, 4, c);
      act(PIN_VEVN, 1'b1, 10, c);
      chk("even_field", f != 1, c);
      act(PIN_VEVN, 1'b0, 4, c);
    end
    wr(ADDR_TV, 32'h7);
    wr(ADDR_LINE, 32'h3);
    act(PIN_VODD, 1'b1, 4, c);
    act(PIN_VODD, 1'b0, 4, c);
    for (k = 1; k < 5; k++)
    begin
      act(PIN_HS, 1'b1, 8, c);
      chk("line_fire", k == 3, c);
      act(PIN_HS, 1'b0, 4, c);
    end
    wr(ADDR_TV, 32'h0);
    @(posedge CORE_CLK);
    chk("tv_off_free", 1, FREE_RUN);
    print_verdict();
  end
endmodule : tb
